// File: rtl/sebf_defs.svh
// Constants for the serial EEPROM bus slave front end.
// How it works
// - Master makes clock, START and STOP.
// - Receive or transmit as direction bit says.
// - Answer only when select bits match pins.
// - Sample on clock rise, change after fall.
// - Data line driven low or released only.
// - Write-inhibit high blocks every memory write.
// - Undriven select inputs read as zero; the code adds no pull-down.
// - Reset holds logic until supply is good.
// - Ready for commands within 1 ms.
// - Ignore pulses up to 100 ns.
// - START and STOP only while clock high.
// - Address is 1010, select bits, direction.
// - Acknowledge address and bytes on ninth clock.
// - No address acknowledge while write busy.
`ifndef SEBF_DEFS_SVH
`define SEBF_DEFS_SVH
`define SEBF_SYS_NS 5
`define SEBF_LINK_NS 32
`define SEBF_GLITCH_NS 100
`define SEBF_FILT_CYC ((`SEBF_GLITCH_NS+`SEBF_LINK_NS-1)/`SEBF_LINK_NS+1)
`define SEBF_PU_MS 1
`define SEBF_PU_CYC (`SEBF_PU_MS*1000000/`SEBF_SYS_NS)
`define SEBF_WR_MS 5
`define SEBF_WR_CYC (`SEBF_WR_MS*1000000/`SEBF_SYS_NS)
`define SEBF_CNT_W 20
`define SEBF_PREFIX 4'hA
`define SEBF_IDLE_BYTE 8'hFF
`define SEBF_BYTE_BITS 4'h8
`define SEBF_FIFO_DEPTH 8
`define SEBF_RX_W 9
`endif

// File: rtl/sebf_fifo.sv
// Synchronous FIFO with a registered output stage.
`timescale 1ns/1ps
module sebf_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  // DEPTH must be a power of two so the pointers wrap by themselves.
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic ov_r, ov_nxt;
  logic [WIDTH-1:0] od_r, od_nxt;
  logic push, pop;

  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = ov_r;
  assign out_data = od_r;

  // Pointer, fill level and output stage next values.
  always_comb begin
    push = in_valid && in_ready;
    pop = (cnt_r != '0) && (!ov_r || out_ready);
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = pop ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    ov_nxt = pop ? 1'b1 : (out_ready ? 1'b0 : ov_r);
    od_nxt = pop ? mem_r[rp_r] : od_r;
  end

  // Storage array; it needs no reset.
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  // Control registers.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      ov_r <= 1'b0;
      od_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      ov_r <= ov_nxt;
      od_r <= od_nxt;
    end
  end
endmodule : sebf_fifo

// File: rtl/sebf_front.sv
// Two-wire bus slave front end of a serial EEPROM.
`timescale 1ns/1ps
`include "sebf_defs.svh"
module sebf_front #(
  parameter int PU_CYC = `SEBF_PU_CYC,
  parameter int WR_CYC = `SEBF_WR_CYC
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clk_link,
  input wire logic scl_pin,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic select_input_bit0,
  input wire logic select_input_bit1,
  input wire logic select_input_bit2,
  input wire logic write_inhibit,
  output logic rx_valid,
  input wire logic rx_ready,
  output sebf_pkg::sebf_rx_t rx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data,
  output logic prog_busy,
  output logic dev_ready,
  output logic wr_commit,
  output logic wr_blocked
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic wp_s1_r, wp_s2_r;
  logic rxq_s1_r, rxq_s2_r, rx_seen_r, rx_seen_nxt;
  logic txa_s1_r, txa_s2_r;
  logic tx_req_r, tx_req_nxt, tx_ready_r, tx_ready_nxt;
  logic [7:0] tx_hold_r, tx_hold_nxt;
  logic cm_s1_r, cm_s2_r, cm_seen_r, cm_seen_nxt;
  logic commit_r, commit_nxt;
  logic [`SEBF_CNT_W-1:0] pu_cnt_r, pu_cnt_nxt, wr_cnt_r, wr_cnt_nxt;
  logic ready_r, ready_nxt, busy_r, busy_nxt;
  logic fifo_in_valid, fifo_in_ready;
  logic lrs1_r, lrs2_r, lrst_n;
  logic [4:0] pin_s1_r, pin_s2_r;
  logic [1:0] line_f;
  logic scl_f, sda_f, scl_q_r, sda_q_r;
  logic rise, fall, start, stop, addr_hit, rx_pend, tx_have;
  logic rxa_s1_r, rxa_s2_r, txq_s1_r, txq_s2_r;
  logic bsy_s1_r, bsy_s2_r, rdy_s1_r, rdy_s2_r;
  sebf_pkg::sebf_lst_t st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] sh_r, sh_nxt, tx_byte;
  logic rw_r, rw_nxt, first_r, first_nxt, wrote_r, wrote_nxt;
  logic mack_r, mack_nxt, oe_n_r, oe_n_nxt, sda_out_r;
  logic rx_req_r, rx_req_nxt, tx_ack_r, tx_ack_nxt, cmt_r, cmt_nxt;
  sebf_pkg::sebf_rx_t rx_hold_r, rx_hold_nxt;

  // ----------------------------------------------------------------
  // System clock domain
  // ----------------------------------------------------------------
  // Synchronisers for the inhibit pin and the link-side toggles.
  always_ff @(posedge clk_sys) begin
    wp_s1_r <= write_inhibit;
    wp_s2_r <= wp_s1_r;
    rxq_s1_r <= rx_req_r;
    rxq_s2_r <= rxq_s1_r;
    txa_s1_r <= tx_ack_r;
    txa_s2_r <= txa_s1_r;
    cm_s1_r <= cmt_r;
    cm_s2_r <= cm_s1_r;
  end

  // A byte is pending while the link toggle differs from the last seen.
  assign fifo_in_valid = (rxq_s2_r != rx_seen_r);

  // Next values for handshakes, ready delay and programming interval.
  always_comb begin
    rx_seen_nxt = rx_seen_r;
    if (fifo_in_valid && fifo_in_ready) begin
      rx_seen_nxt = rxq_s2_r;
    end
    tx_req_nxt = tx_req_r;
    tx_hold_nxt = tx_hold_r;
    tx_ready_nxt = (tx_req_r == txa_s2_r);
    if (tx_valid && tx_ready_r) begin
      tx_req_nxt = ~tx_req_r;
      tx_hold_nxt = tx_data;
      tx_ready_nxt = 1'b0;
    end
    pu_cnt_nxt = pu_cnt_r;
    ready_nxt = ready_r;
    if (!ready_r) begin
      pu_cnt_nxt = pu_cnt_r + 1'b1;
      if (pu_cnt_r == `SEBF_CNT_W'(PU_CYC - 1)) begin
        ready_nxt = 1'b1;
      end
    end
    cm_seen_nxt = cm_s2_r;
    commit_nxt = 1'b0;
    wr_cnt_nxt = wr_cnt_r;
    busy_nxt = busy_r;
    if (busy_r) begin
      wr_cnt_nxt = wr_cnt_r - 1'b1;
      if (wr_cnt_r == `SEBF_CNT_W'(1)) begin
        busy_nxt = 1'b0;
      end
    end
    // A write asked for while the inhibit pin is high is dropped.
    if ((cm_s2_r != cm_seen_r) && !wp_s2_r) begin
      commit_nxt = 1'b1;
      busy_nxt = 1'b1;
      wr_cnt_nxt = `SEBF_CNT_W'(WR_CYC);
    end
  end

  // System registers; reset stands for the power-on reset.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rx_seen_r <= 1'b0;
      tx_req_r <= 1'b0;
      tx_hold_r <= 8'h00;
      tx_ready_r <= 1'b0;
      pu_cnt_r <= '0;
      ready_r <= 1'b0;
      cm_seen_r <= 1'b0;
      commit_r <= 1'b0;
      wr_cnt_r <= '0;
      busy_r <= 1'b0;
    end else begin
      rx_seen_r <= rx_seen_nxt;
      tx_req_r <= tx_req_nxt;
      tx_hold_r <= tx_hold_nxt;
      tx_ready_r <= tx_ready_nxt;
      pu_cnt_r <= pu_cnt_nxt;
      ready_r <= ready_nxt;
      cm_seen_r <= cm_seen_nxt;
      commit_r <= commit_nxt;
      wr_cnt_r <= wr_cnt_nxt;
      busy_r <= busy_nxt;
    end
  end

  // Received bytes queue here; a full queue holds off the link.
  sebf_fifo #(
    .WIDTH(`SEBF_RX_W),
    .DEPTH(`SEBF_FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(rx_hold_r),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data)
  );

  assign tx_ready = tx_ready_r;
  assign prog_busy = busy_r;
  assign dev_ready = ready_r;
  assign wr_commit = commit_r;
  assign wr_blocked = wp_s2_r;

  // ----------------------------------------------------------------
  // Link clock domain
  // ----------------------------------------------------------------
  // Reset, pins and system levels brought onto the link clock.
  // Select pins are sampled as driven; nothing here pulls open pins to zero.
  always_ff @(posedge clk_link) begin
    lrs1_r <= rstn;
    lrs2_r <= lrs1_r;
    pin_s1_r <= {select_input_bit2, select_input_bit1,
                 select_input_bit0, sda_in, scl_pin};
    pin_s2_r <= pin_s1_r;
    rxa_s1_r <= rx_seen_r;
    rxa_s2_r <= rxa_s1_r;
    txq_s1_r <= tx_req_r;
    txq_s2_r <= txq_s1_r;
    bsy_s1_r <= busy_r;
    bsy_s2_r <= bsy_s1_r;
    rdy_s1_r <= ready_r;
    rdy_s2_r <= rdy_s1_r;
  end
  assign lrst_n = lrs2_r;

  // Each line only changes after a run of steady differing samples.
  for (genvar i = 0; i < 2; i++) begin : g_filt
    logic [2:0] fc_r, fc_nxt;
    logic f_r, f_nxt;
    always_comb begin
      f_nxt = f_r;
      fc_nxt = 3'h0;
      if (pin_s2_r[i] != f_r) begin
        fc_nxt = fc_r + 3'h1;
        if (fc_r == 3'(`SEBF_FILT_CYC - 1)) begin
          f_nxt = pin_s2_r[i];
          fc_nxt = 3'h0;
        end
      end
    end
    always_ff @(posedge clk_link) begin
      if (!lrst_n) begin
        f_r <= 1'b1;
        fc_r <= 3'h0;
      end else begin
        f_r <= f_nxt;
        fc_r <= fc_nxt;
      end
    end
    assign line_f[i] = f_r;
  end

  // The clock line is only ever sampled here, never driven.
  assign scl_f = line_f[0];
  assign sda_f = line_f[1];
  assign rise = scl_f && !scl_q_r;
  assign fall = !scl_f && scl_q_r;
  assign start = scl_f && scl_q_r && sda_q_r && !sda_f;
  assign stop = scl_f && scl_q_r && !sda_q_r && sda_f;
  assign rx_pend = (rx_req_r != rxa_s2_r);
  assign tx_have = (txq_s2_r != tx_ack_r);
  assign tx_byte = tx_have ? tx_hold_r : `SEBF_IDLE_BYTE;
  // Prefix, select pins, ready and not programming.
  assign addr_hit = (sh_r[7:4] == `SEBF_PREFIX)
    && (sh_r[3:1] == pin_s2_r[4:2])
    && rdy_s2_r && !bsy_s2_r;

  // Transfer state machine next values.
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    rw_nxt = rw_r;
    first_nxt = first_r;
    wrote_nxt = wrote_r;
    mack_nxt = mack_r;
    oe_n_nxt = oe_n_r;
    rx_req_nxt = rx_req_r;
    rx_hold_nxt = rx_hold_r;
    tx_ack_nxt = tx_ack_r;
    cmt_nxt = cmt_r;
    if (stop) begin
      st_nxt = sebf_pkg::L_IDLE;
      oe_n_nxt = 1'b1;
      wrote_nxt = 1'b0;
      if (wrote_r) begin
        cmt_nxt = ~cmt_r;
      end
    end else if (start) begin
      st_nxt = sebf_pkg::L_ADDR;
      cnt_nxt = 4'h0;
      oe_n_nxt = 1'b1;
      wrote_nxt = 1'b0;
    end else begin
      unique case (st_r)
        sebf_pkg::L_IDLE: begin
          oe_n_nxt = 1'b1;
        end
        sebf_pkg::L_ADDR, sebf_pkg::L_RX: begin
          if (rise && cnt_r != `SEBF_BYTE_BITS) begin
            sh_nxt = {sh_r[6:0], sda_f};
            cnt_nxt = cnt_r + 4'h1;
          end else if (fall && cnt_r == `SEBF_BYTE_BITS) begin
            if (st_r == sebf_pkg::L_ADDR) begin
              if (addr_hit) begin
                oe_n_nxt = 1'b0;
                rw_nxt = sh_r[0];
                first_nxt = 1'b1;
                st_nxt = sebf_pkg::L_ACK;
              end else begin
                st_nxt = sebf_pkg::L_IDLE;
              end
            end else if (!rx_pend) begin
              oe_n_nxt = 1'b0;
              rx_hold_nxt.first = first_r;
              rx_hold_nxt.data = sh_r;
              rx_req_nxt = ~rx_req_r;
              wrote_nxt = wrote_r || !first_r;
              first_nxt = 1'b0;
              st_nxt = sebf_pkg::L_ACK;
            end else begin
              st_nxt = sebf_pkg::L_IDLE;
            end
          end
        end
        sebf_pkg::L_ACK: begin
          if (fall) begin
            cnt_nxt = 4'h0;
            if (rw_r) begin
              sh_nxt = {tx_byte[6:0], 1'b0};
              oe_n_nxt = tx_byte[7];
              tx_ack_nxt = tx_ack_r ^ tx_have;
              st_nxt = sebf_pkg::L_TX;
            end else begin
              oe_n_nxt = 1'b1;
              st_nxt = sebf_pkg::L_RX;
            end
          end
        end
        sebf_pkg::L_TX: begin
          if (rise) begin
            cnt_nxt = cnt_r + 4'h1;
          end else if (fall) begin
            if (cnt_r == `SEBF_BYTE_BITS) begin
              oe_n_nxt = 1'b1;
              st_nxt = sebf_pkg::L_TXACK;
            end else begin
              oe_n_nxt = sh_r[7];
              sh_nxt = {sh_r[6:0], 1'b0};
            end
          end
        end
        sebf_pkg::L_TXACK: begin
          if (rise) begin
            mack_nxt = !sda_f;
          end else if (fall) begin
            cnt_nxt = 4'h0;
            if (mack_r) begin
              sh_nxt = {tx_byte[6:0], 1'b0};
              oe_n_nxt = tx_byte[7];
              tx_ack_nxt = tx_ack_r ^ tx_have;
              st_nxt = sebf_pkg::L_TX;
            end else begin
              st_nxt = sebf_pkg::L_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Link registers; the data output only ever drives low.
  always_ff @(posedge clk_link) begin
    if (!lrst_n) begin
      st_r <= sebf_pkg::L_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      rw_r <= 1'b0;
      first_r <= 1'b0;
      wrote_r <= 1'b0;
      mack_r <= 1'b0;
      oe_n_r <= 1'b1;
      rx_req_r <= 1'b0;
      rx_hold_r <= '0;
      tx_ack_r <= 1'b0;
      cmt_r <= 1'b0;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      sda_out_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      rw_r <= rw_nxt;
      first_r <= first_nxt;
      wrote_r <= wrote_nxt;
      mack_r <= mack_nxt;
      oe_n_r <= oe_n_nxt;
      rx_req_r <= rx_req_nxt;
      rx_hold_r <= rx_hold_nxt;
      tx_ack_r <= tx_ack_nxt;
      cmt_r <= cmt_nxt;
      scl_q_r <= scl_f;
      sda_q_r <= sda_f;
      sda_out_r <= 1'b0;
    end
  end

  assign sda_out = sda_out_r;
  assign sda_oe_n = oe_n_r;
endmodule : sebf_front

// File: rtl/sebf_pkg.sv
// Types shared by the serial EEPROM bus slave front end.
package sebf_pkg;
  // One received byte and whether it is the first after the address.
  typedef struct packed {
    logic first;
    logic [7:0] data;
  } sebf_rx_t;
  // Link-side transfer states.
  typedef enum logic [2:0] {
    L_IDLE, L_ADDR, L_RX, L_ACK, L_TX, L_TXACK
  } sebf_lst_t;
endpackage : sebf_pkg

// File: verif/sebf_chk.sv
// Port assertions of the bus slave front end.
`timescale 1ns/1ps
module sebf_chk #(
  parameter int PU_CYC = 40,
  parameter int WR_CYC = 200
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clk_link,
  input wire logic scl_pin,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire sebf_pkg::sebf_rx_t rx_data,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic prog_busy,
  input wire logic dev_ready,
  input wire logic wr_commit,
  input wire logic wr_blocked
);
  // ---------------------------------
  // Helper counters and properties
  // ---------------------------------
  int up_r, up_nxt, bz_r, bz_nxt;
  // Counts cycles since reset release and cycles of programming.
  always_comb begin
    up_nxt = (up_r < PU_CYC) ? up_r + 1 : up_r;
    bz_nxt = prog_busy ? bz_r + 1 : 0;
  end
  // Registers the counters.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      up_r <= 0;
      bz_r <= 0;
    end else begin
      up_r <= up_nxt;
      bz_r <= bz_nxt;
    end
  end
  property p_sda_low;
    @(posedge clk_link) disable iff (!rstn) sda_out == 1'b0;
  endproperty
  a_sda_low: assert property (p_sda_low)
    else $error("data pin driven high");
  property p_oe_scl_low;
    @(posedge clk_link) disable iff (!rstn) $changed(sda_oe_n) |-> !scl_pin;
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low)
    else $error("data pin changed while clock high");
  property p_commit_busy;
    @(posedge clk_sys) disable iff (!rstn)
      wr_commit |-> prog_busy ##1 !wr_commit;
  endproperty
  a_commit_busy: assert property (p_commit_busy)
    else $error("commit pulse without busy");
  property p_busy_len;
    @(posedge clk_sys) disable iff (!rstn)
      $fell(prog_busy) |-> bz_r >= WR_CYC - 1 && bz_r <= WR_CYC + 1;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("programming time wrong");
  property p_blocked;
    @(posedge clk_sys) disable iff (!rstn) wr_commit |-> !wr_blocked;
  endproperty
  a_blocked: assert property (p_blocked)
    else $error("commit while inhibited");
  property p_busy_nack;
    @(posedge clk_sys) disable iff (!rstn)
      prog_busy && $past(prog_busy, 8) |-> sda_oe_n;
  endproperty
  a_busy_nack: assert property (p_busy_nack)
    else $error("acknowledge while busy");
  property p_ready_time;
    @(posedge clk_sys) disable iff (!rstn) dev_ready |-> up_r >= PU_CYC - 1;
  endproperty
  a_ready_time: assert property (p_ready_time)
    else $error("ready too early");
  property p_reset;
    @(posedge clk_sys) disable iff (!rstn)
      $rose(rstn) |-> !dev_ready && !prog_busy && !rx_valid && !wr_commit;
  endproperty
  a_reset: assert property (p_reset)
    else $error("outputs not reset");
  property p_tx_take;
    @(posedge clk_sys) disable iff (!rstn) tx_valid && tx_ready |=> !tx_ready;
  endproperty
  a_tx_take: assert property (p_tx_take)
    else $error("slot still free after take");
  property p_rx_hold;
    @(posedge clk_sys) disable iff (!rstn)
      rx_valid && !rx_ready |=> rx_valid && $stable(rx_data);
  endproperty
  a_rx_hold: assert property (p_rx_hold)
    else $error("received word dropped");
endmodule : sebf_chk

bind sebf_front sebf_chk #(.PU_CYC(PU_CYC), .WR_CYC(WR_CYC)) u_chk (.*);

// File: verif/sebf_master.sv
// Behavioural two-wire bus master facing the slave front end.
`timescale 1ns/1ps
module sebf_master (
  output logic scl,
  output logic sda_rel,
  input wire logic sda
);
  // ---------------------------------
  // Bus cycles
  // ---------------------------------
  localparam int H = 600;
  logic glitch;
  // Both lines idle high: the clock driven high, the data released to its pull-up.
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
    glitch = 1'b0;
  end
  // Data falls while the clock is high.
  task automatic start();
    #(H/2);
    sda_rel = 1'b1;
    #(H/2);
    scl = 1'b1;
    #H;
    sda_rel = 1'b0;
    #H;
    scl = 1'b0;
  endtask : start
  // Data rises while the clock is high.
  task automatic stop();
    #(H/2);
    sda_rel = 1'b0;
    #(H/2);
    scl = 1'b1;
    #H;
    sda_rel = 1'b1;
    #H;
  endtask : stop
  // One clock; glitch adds 100 ns pulses on the clock and the data.
  task automatic bit_io(input logic b, output logic s);
    #(H/2);
    sda_rel = b;
    if (glitch) begin
      #100 scl = 1'b1;
      #100 scl = 1'b0;
      #(H/2 - 200);
    end else begin
      #(H/2);
    end
    scl = 1'b1;
    if (glitch) begin
      #100 sda_rel = !b;
      #100 sda_rel = b;
      #(H/2 - 200);
    end else begin
      #(H/2);
    end
    s = sda;
    #(H/2);
    scl = 1'b0;
  endtask : bit_io
  // Sends a byte, most significant bit first.
  task automatic wr(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask : wr
  // Reads a byte and answers with the given acknowledge.
  task automatic rd(input logic mack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(!mack, s);
  endtask : rd
endmodule : sebf_master

// File: verif/tb_top.sv
// Self-checking testbench of the bus slave front end.
`timescale 1ns/1ps
module tb_top;
  // ---------------------------------
  // Stimulus and checks
  // ---------------------------------
  logic clk_sys = 1'b0;
  logic clk_link = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] sel = 3'h5;
  logic wi = 1'b0;
  logic rx_ready = 1'b0;
  logic tx_valid = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic scl, m_rel, sda, sda_out, sda_oe_n, rx_valid, tx_ready;
  logic prog_busy, dev_ready, wr_blocked, wr_commit;
  sebf_pkg::sebf_rx_t rx_data;
  int failures = 0;
  int num_checks = 0;
  int n_commit = 0;
  // Clocks of unrelated phase.
  always #2.5 clk_sys = ~clk_sys;
  initial #1.3 forever #16 clk_link = ~clk_link;
  // Wired-and data line with pull-up.
  assign sda = m_rel & (sda_oe_n | sda_out);
  sebf_master m (.scl(scl), .sda_rel(m_rel), .sda(sda));
  // Counts commit pulses away from the edge that launches them.
  always @(negedge clk_sys) begin
    if (wr_commit === 1'b1) begin
      n_commit++;
    end
  end
  sebf_front #(.PU_CYC(40), .WR_CYC(4000)) dut (
    .clk_sys(clk_sys), .rstn(rstn), .clk_link(clk_link),
    .scl_pin(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .select_input_bit0(sel[0]), .select_input_bit1(sel[1]),
    .select_input_bit2(sel[2]), .write_inhibit(wi),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .prog_busy(prog_busy), .dev_ready(dev_ready), .wr_commit(wr_commit),
    .wr_blocked(wr_blocked));
  // Prints the counts and the verdict.
  task automatic summarize();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize
  // Compares one value.
  task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Bounded wait for a level.
  task automatic wt(input string n, ref logic s, input logic v,
                    input int lim);
    int k;
    k = 0;
    while (s !== v && k < lim) begin
      @(negedge clk_sys);
      k++;
    end
    if (s !== v) begin
      failures++;
      $display("Error %s expected %b seen %b", n, v, s);
      summarize();
    end
  endtask : wt
  // Slave address of memory access.
  function automatic logic [7:0] adr(input logic [2:0] s, input logic r);
    return {4'hA, s, r};
  endfunction : adr
  // Takes one received word; the negedge lets a previous take settle.
  task automatic drain(input logic [8:0] e);
    @(negedge clk_sys);
    wt("rx_valid", rx_valid, 1'b1, 100);
    chk("rx_word", e, rx_data);
    @(posedge clk_sys);
    rx_ready <= 1'b1;
    @(posedge clk_sys);
    rx_ready <= 1'b0;
  endtask : drain
  // Only a matching select code and prefix are acknowledged.
  task automatic t_select();
    logic a;
    for (int k = 0; k < 8; k++) begin
      m.start();
      m.wr(adr(3'(k), 1'b0), a);
      m.stop();
      chk("sel_ack", 9'(3'(k) == sel), 9'(a));
    end
    m.start();
    m.wr({4'h6, sel, 1'b0}, a);
    m.stop();
    chk("pfx_ack", 9'h000, 9'(a));
  endtask : t_select
  // Write with stalled consumer, a clock glitch and a busy poll.
  task automatic t_write();
    logic a0, a1, a2, a3;
    m.start();
    m.wr(adr(sel, 1'b0), a0);
    m.wr(8'h3C, a1);
    m.glitch = 1'b1;
    m.wr(8'hA5, a2);
    m.glitch = 1'b0;
    m.wr(8'h5A, a3);
    m.stop();
    chk("wr_acks", 9'h00F, {5'h00, a0, a1, a2, a3});
    @(negedge clk_sys);
    chk("busy", 9'h001, 9'(prog_busy));
    chk("commits", 9'h001, 9'(n_commit));
    m.start();
    m.wr(adr(sel, 1'b1), a0);
    m.stop();
    chk("poll_ack", 9'h000, 9'(a0));
    wt("prog_busy", prog_busy, 1'b0, 5000);
    drain({1'b1, 8'h3C});
    drain({1'b0, 8'hA5});
    drain({1'b0, 8'h5A});
  endtask : t_write
  // Read of one offered byte, then an empty slot.
  task automatic t_read();
    logic a;
    logic [7:0] d0, d1;
    @(posedge clk_sys);
    tx_data <= 8'hC3;
    tx_valid <= 1'b1;
    wt("tx_ready", tx_ready, 1'b1, 50);
    @(posedge clk_sys);
    tx_valid <= 1'b0;
    m.start();
    m.wr(adr(sel, 1'b1), a);
    m.rd(1'b1, d0);
    m.rd(1'b0, d1);
    m.stop();
    chk("rd_ack", 9'h001, 9'(a));
    chk("rd_byte", 9'h0C3, 9'(d0));
    chk("rd_empty", 9'h0FF, 9'(d1));
  endtask : t_read
  // Inhibited write is queued but never programmed.
  task automatic t_inhibit();
    logic a0, a1, a2;
    @(posedge clk_sys);
    wi <= 1'b1;
    m.start();
    m.wr(adr(sel, 1'b0), a0);
    m.wr(8'h10, a1);
    m.wr(8'h77, a2);
    m.stop();
    chk("blocked", 9'h001, 9'(wr_blocked));
    repeat (20) @(negedge clk_sys);
    chk("no_busy", 9'h000, 9'(prog_busy));
    chk("commits", 9'h001, 9'(n_commit));
    drain({1'b1, 8'h10});
    drain({1'b0, 8'h77});
    wi <= 1'b0;
  endtask : t_inhibit
  // Main sequence.
  initial begin
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    wt("dev_ready", dev_ready, 1'b1, 100);
    repeat (20) @(posedge clk_sys);
    t_select();
    t_write();
    t_read();
    t_inhibit();
    summarize();
  end
endmodule : tb_top
